// file: dag_defines.svh
`ifndef DAG_DEFINES_SVH
`define DAG_DEFINES_SVH
`define DAG_OFS_BREV 12'h000
`define DAG_OFS_STAT 12'h004
`define DAG_BREV_RST 16'h0000
`define DAG_BREV_EN_BIT 15
`define DAG_BREV_MOD_MSB 14
`define DAG_BREV_MOD_MIN 15'h0002
`define DAG_STAT_ACT_BIT 0
`define DAG_STAT_SELERR_BIT 1
`define DAG_STAT_FWR_BIT 2
`define DAG_STAT_FEA_LSB 16
`define DAG_STEP_WORD 16'h0002
`define DAG_STEP_BYTE 16'h0001
`define DAG_WREG_X0 4'h8
`define DAG_WREG_X1 4'h9
`define DAG_WREG_Y0 4'hA
`define DAG_WREG_Y1 4'hB
`define DAG_BE_WORD 2'h3
`define DAG_BE_LO 2'h1
`define DAG_BE_HI 2'h2
`endif

// file: dag_pkg.sv
package dag_pkg;
  typedef enum logic [1:0] {
    DAG_PM_NONE = 2'h0,
    DAG_PM_INC = 2'h1,
    DAG_PM_DEC = 2'h3
  } dag_pm_e;
  typedef struct packed {
    logic brev_en;
    logic [14:0] brev_mod;
    logic [15:0] xr_ea;
    logic xr_en;
    logic xr_byte;
    logic xr_ok;
    logic [15:0] y_ea;
    logic y_en;
    logic y_ok;
    logic rd_valid;
    logic [15:0] x_rd_data;
    logic [15:0] y_rd_data;
    logic [15:0] xr_ptr_upd;
    logic [15:0] y_ptr_upd;
    logic xw_pend;
    logic [15:0] xw_ea;
    logic xw_byte;
    logic [15:0] xw_data;
    logic [15:0] xw_ptr_upd;
    logic x_wr_en;
    logic [15:0] x_wr_addr;
    logic [1:0] x_wr_be;
    logic [15:0] x_wr_data;
    logic trap;
    logic [15:0] fault_ea;
    logic fault_wr;
    logic sel_err;
    logic [31:0] prdata;
  } dag_state_s;
endpackage

// file: dag_agu.sv
// Function
// [RQ1] Modifier field is one power of two, half the buffer words, 0x0002 to 0x4000.
// [RQ2] Enable bit set turns bit-reversed write addressing on, clear turns it off.
// [RQ3] Every generator forms any effective address over the full 64-Kbyte space.
// [RQ4] Reads beyond implemented memory return zeros; writes there change nothing.
// [RQ5] X read and X write generators are independent, separate buses and phases.
// [RQ6] All data writes travel over the X write bus only.
// [RQ7] X read address computed in prior cycle, presented at cycle start.
// [RQ8] X write address computed at cycle start, presented in the write phase.
// [RQ9] Modulo in X read and X write; bit reversal in X write only.
// [RQ10] Y generator serves dual-operand reads only, never writes.
// [RQ11] Y generator uses the same timing as the X read generator.
// [RQ12] Y generator offers only post-modify and modulo addressing.
// [RQ13] DSP reads use registers 8 and 9 for X, 10 and 11 for Y.
// [RQ14] DSP-class writes go over the X bus to any address.
// [RQ15] Non-DSP reads reach Y space through the X generator as one space.
// [RQ16] Word operations ignore address bit 0.
// [RQ17] Words are little-endian: low byte even address, high byte odd.
// [RQ18] Byte reads select by bit 0 and deliver on the low 8 bits.
// [RQ19] Word post-modify moves the pointer by 2.
// [RQ20] Odd word access traps; the read completes, the write is suppressed.
// [RQ21] Byte post-modify moves the pointer by 1.
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
`include "dag_defines.svh"
module dag_agu #(
  parameter logic [15:0] MEM_TOP = 16'h7FFF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Instruction cycle timing
  input wire logic cyc_start,
  input wire logic wr_phase,
  // X read request
  input wire logic xr_req,
  input wire logic xr_dsp,
  input wire logic [3:0] xr_wreg,
  input wire logic [15:0] xr_ptr,
  input wire logic xr_byte,
  input wire dag_pkg::dag_pm_e xr_pm,
  input wire logic xr_mod_en,
  // Y read request
  input wire logic y_req,
  input wire logic [3:0] y_wreg,
  input wire logic [15:0] y_ptr,
  input wire dag_pkg::dag_pm_e y_pm,
  input wire logic y_mod_en,
  // X write request
  input wire logic xw_req,
  input wire logic [15:0] xw_ptr,
  input wire logic xw_byte,
  input wire dag_pkg::dag_pm_e xw_pm,
  input wire logic xw_mod_en,
  input wire logic xw_brev,
  input wire logic [15:0] xw_data,
  // Modulo bounds
  input wire logic [15:0] x_mod_start,
  input wire logic [15:0] x_mod_end,
  input wire logic [15:0] y_mod_start,
  input wire logic [15:0] y_mod_end,
  // Memory buses
  output logic [15:0] x_rd_addr,
  output logic x_rd_en,
  input wire logic [15:0] x_mem_rdata,
  output logic [15:0] y_rd_addr,
  output logic y_rd_en,
  input wire logic [15:0] y_mem_rdata,
  output logic [15:0] x_wr_addr,
  output logic x_wr_en,
  output logic [1:0] x_wr_be,
  output logic [15:0] x_wr_data,
  // Results to the pipeline
  output logic [15:0] x_rd_data,
  output logic [15:0] y_rd_data,
  output logic rd_valid,
  output logic [15:0] xr_ptr_upd,
  output logic [15:0] y_ptr_upd,
  output logic [15:0] xw_ptr_upd,
  output logic addr_err_trap
);

  if (MEM_TOP[0] != 1'b1)
  begin : g_chk
    $error("MEM_TOP must be odd");
  end

  dag_pkg::dag_state_s s_q;
  dag_pkg::dag_state_s s_d;

  // Post-modify with optional modulo wrap
  function automatic logic [15:0] postmod(
    input logic [15:0] ptr,
    input dag_pkg::dag_pm_e pm,
    input logic byte_op,
    input logic mod_en,
    input logic [15:0] ms,
    input logic [15:0] me
  );
    logic [15:0] step;
    logic at_end;
    logic at_start;
    step = byte_op ? `DAG_STEP_BYTE : `DAG_STEP_WORD; // [RQ19] [RQ21]
    at_end = byte_op ? (ptr == me) : (ptr[15:1] == me[15:1]);
    at_start = ptr == ms;
    postmod = ptr;
    if (pm == dag_pkg::DAG_PM_INC)
      postmod = (mod_en && at_end) ? ms : ptr + step;
    else if (pm == dag_pkg::DAG_PM_DEC)
      postmod = (mod_en && at_start) ? (byte_op ? me : {me[15:1], 1'b0}) : ptr - step;
  endfunction

  // Bit-reversed carry add for the write pointer
  logic [15:0] brev_step;
  logic [15:0] ptr_rev;
  logic [15:0] step_rev;
  logic [15:0] rev_sum;
  logic [15:0] brev_next;
  logic brev_legal;
  logic brev_act;
  assign brev_step = {s_q.brev_mod, 1'b0};
  assign rev_sum = ptr_rev + step_rev;
  for (genvar i = 0; i < 16; i++)
  begin : g_rev
    assign ptr_rev[i] = xw_ptr[15 - i];
    assign step_rev[i] = brev_step[15 - i];
    assign brev_next[i] = rev_sum[15 - i];
  end
  // Only a single power of two from the smallest buffer upward is served
  assign brev_legal = (s_q.brev_mod >= `DAG_BREV_MOD_MIN)
    && ((s_q.brev_mod & (s_q.brev_mod - 15'h0001)) == 15'h0000); // [RQ1]
  assign brev_act = s_q.brev_en && brev_legal; // [RQ2]

  // Request qualification
  logic xr_sel_ok;
  logic y_sel_ok;
  logic apb_wr;
  logic apb_setup;
  logic map_brev;
  logic map_stat;
  assign xr_sel_ok = !xr_dsp || xr_wreg == `DAG_WREG_X0 || xr_wreg == `DAG_WREG_X1; // [RQ13] [RQ15]
  assign y_sel_ok = y_wreg == `DAG_WREG_Y0 || y_wreg == `DAG_WREG_Y1; // [RQ13]
  assign map_brev = paddr == `DAG_OFS_BREV;
  assign map_stat = paddr == `DAG_OFS_STAT;
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite && pready;
  assign pready = ce;
  assign pslverr = psel && penable && !map_brev && !map_stat;

  always_comb
  begin
    s_d = s_q;
    s_d.rd_valid = 1'b0;
    s_d.xr_en = 1'b0;
    s_d.y_en = 1'b0;
    s_d.x_wr_en = 1'b0;
    s_d.trap = 1'b0;
    // Registers
    if (apb_wr && map_brev)
    begin
      s_d.brev_en = pwdata[`DAG_BREV_EN_BIT]; // [RQ2]
      s_d.brev_mod = pwdata[`DAG_BREV_MOD_MSB:0]; // [RQ1]
    end
    if (apb_wr && map_stat && pwdata[`DAG_STAT_SELERR_BIT])
      s_d.sel_err = 1'b0;
    if (apb_setup)
    begin
      s_d.prdata = 32'h0000_0000;
      if (map_brev)
        s_d.prdata[15:0] = {s_q.brev_en, s_q.brev_mod};
      else if (map_stat)
      begin
        s_d.prdata[`DAG_STAT_ACT_BIT] = brev_act;
        s_d.prdata[`DAG_STAT_SELERR_BIT] = s_q.sel_err;
        s_d.prdata[`DAG_STAT_FWR_BIT] = s_q.fault_wr;
        s_d.prdata[31:`DAG_STAT_FEA_LSB] = s_q.fault_ea;
      end
    end
    // Read data return, one clock after the read bus cycle
    if (s_q.xr_en || s_q.y_en)
      s_d.rd_valid = 1'b1;
    if (s_q.xr_en)
    begin
      if (!s_q.xr_ok)
        s_d.x_rd_data = 16'h0000; // [RQ4]
      else if (s_q.xr_byte)
        s_d.x_rd_data = {8'h00, s_q.xr_ea[0] ? x_mem_rdata[15:8] : x_mem_rdata[7:0]}; // [RQ18] [RQ17]
      else
        s_d.x_rd_data = x_mem_rdata; // [RQ16]
    end
    if (s_q.y_en)
      s_d.y_rd_data = s_q.y_ok ? y_mem_rdata : 16'h0000; // [RQ4]
    // Read generators load at the cycle boundary from the prefetched decode
    if (cyc_start)
    begin
      if (xr_req && xr_sel_ok)
      begin
        s_d.xr_en = 1'b1; // [RQ7] [RQ5]
        s_d.xr_ea = xr_ptr; // [RQ3] [RQ15]
        s_d.xr_byte = xr_byte;
        s_d.xr_ok = xr_ptr <= MEM_TOP;
        s_d.xr_ptr_upd = postmod(xr_ptr, xr_pm, xr_byte, xr_mod_en, x_mod_start, x_mod_end); // [RQ9]
        if (!xr_byte && xr_ptr[0])
        begin
          s_d.trap = 1'b1; // [RQ20]
          s_d.fault_ea = xr_ptr;
          s_d.fault_wr = 1'b0;
        end
      end
      if (y_req && y_sel_ok)
      begin
        s_d.y_en = 1'b1; // [RQ11] [RQ10]
        s_d.y_ea = y_ptr; // [RQ3]
        s_d.y_ok = y_ptr <= MEM_TOP;
        s_d.y_ptr_upd = postmod(y_ptr, y_pm, 1'b0, y_mod_en, y_mod_start, y_mod_end); // [RQ12]
        if (y_ptr[0])
        begin
          s_d.trap = 1'b1; // [RQ20]
          s_d.fault_ea = y_ptr;
          s_d.fault_wr = 1'b0;
        end
      end
      if ((xr_req && !xr_sel_ok) || (y_req && !y_sel_ok))
        s_d.sel_err = 1'b1;
      // Write generator starts its calculation at the cycle start
      if (xw_req)
      begin
        s_d.xw_pend = 1'b1; // [RQ8] [RQ5]
        s_d.xw_ea = xw_ptr; // [RQ3] [RQ14]
        s_d.xw_byte = xw_byte;
        s_d.xw_data = xw_data;
        if (xw_brev && brev_act && !xw_byte && xw_pm == dag_pkg::DAG_PM_INC)
          s_d.xw_ptr_upd = brev_next; // [RQ9] [RQ1]
        else
          s_d.xw_ptr_upd = postmod(xw_ptr, xw_pm, xw_byte, xw_mod_en, x_mod_start, x_mod_end); // [RQ9]
      end
    end
    // Write bus cycle in the write phase
    if (wr_phase && s_q.xw_pend)
    begin
      // A request taken at this same edge stays pending for its own write phase
      s_d.xw_pend = cyc_start && xw_req;
      s_d.x_wr_addr = {s_q.xw_ea[15:1], s_q.xw_byte & s_q.xw_ea[0]};
      if (!s_q.xw_byte && s_q.xw_ea[0])
      begin
        s_d.trap = 1'b1; // [RQ20]
        s_d.fault_ea = s_q.xw_ea;
        s_d.fault_wr = 1'b1;
      end
      else if (s_q.xw_ea <= MEM_TOP)
      begin
        s_d.x_wr_en = 1'b1; // [RQ6] [RQ4]
        if (!s_q.xw_byte)
        begin
          s_d.x_wr_be = `DAG_BE_WORD;
          s_d.x_wr_data = s_q.xw_data;
        end
        else if (s_q.xw_ea[0])
        begin
          s_d.x_wr_be = `DAG_BE_HI; // [RQ17]
          s_d.x_wr_data = {s_q.xw_data[7:0], 8'h00};
        end
        else
        begin
          s_d.x_wr_be = `DAG_BE_LO; // [RQ17]
          s_d.x_wr_data = {8'h00, s_q.xw_data[7:0]};
        end
      end
    end
    if (!ce)
      s_d = s_q;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_q <= '0;
      s_q.brev_en <= 1'(`DAG_BREV_RST >> `DAG_BREV_EN_BIT);
    end
    else
      s_q <= s_d;
  end

  assign prdata = s_q.prdata;
  // Word addresses on the read buses drop bit 0
  assign x_rd_addr = {s_q.xr_ea[15:1], s_q.xr_byte & s_q.xr_ea[0]}; // [RQ16]
  assign x_rd_en = s_q.xr_en && s_q.xr_ok; // [RQ4]
  assign y_rd_addr = {s_q.y_ea[15:1], 1'b0}; // [RQ16]
  assign y_rd_en = s_q.y_en && s_q.y_ok;
  assign x_wr_addr = s_q.x_wr_addr;
  assign x_wr_en = s_q.x_wr_en;
  assign x_wr_be = s_q.x_wr_be;
  assign x_wr_data = s_q.x_wr_data;
  assign x_rd_data = s_q.x_rd_data;
  assign y_rd_data = s_q.y_rd_data;
  assign rd_valid = s_q.rd_valid;
  assign xr_ptr_upd = s_q.xr_ptr_upd;
  assign y_ptr_upd = s_q.y_ptr_upd;
  assign xw_ptr_upd = s_q.xw_ptr_upd;
  assign addr_err_trap = s_q.trap;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_brev_legal;
    brev_act |-> $onehot(s_q.brev_mod) && !s_q.brev_mod[0];
  endproperty
  a_brev_legal: assert property (p_brev_legal) else $error("illegal modifier active"); // [RQ1]

  property p_brev_en;
    apb_wr && map_brev |=> s_q.brev_en == $past(pwdata[`DAG_BREV_EN_BIT]);
  endproperty
  a_brev_en: assert property (p_brev_en) else $error("enable bit not stored"); // [RQ2]

  property p_rd_zero;
    ce && s_q.xr_en && !s_q.xr_ok |=> rd_valid && x_rd_data == 16'h0000;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("out of range read not zero"); // [RQ4]

  property p_wr_range;
    x_wr_en |-> x_wr_addr <= MEM_TOP;
  endproperty
  a_wr_range: assert property (p_wr_range) else $error("write beyond memory"); // [RQ4]

  property p_rd_time;
    ce && cyc_start && xr_req && !xr_dsp |=> s_q.xr_en && s_q.xr_ea == $past(xr_ptr);
  endproperty
  a_rd_time: assert property (p_rd_time) else $error("read address late"); // [RQ7]

  property p_wr_time;
    x_wr_en && $past(ce) |-> $past(wr_phase && s_q.xw_pend);
  endproperty
  a_wr_time: assert property (p_wr_time) else $error("write outside write phase"); // [RQ8]

  property p_y_sel;
    ce && cyc_start && y_req && !y_sel_ok |=> !y_rd_en && s_q.sel_err;
  endproperty
  a_y_sel: assert property (p_y_sel) else $error("Y read from wrong pointer"); // [RQ13]

  property p_word_step;
    ce && cyc_start && xr_req && !xr_dsp && !xr_byte && !xr_mod_en
      && xr_pm == dag_pkg::DAG_PM_INC |=> xr_ptr_upd == $past(xr_ptr) + 16'h0002;
  endproperty
  a_word_step: assert property (p_word_step) else $error("word step not 2"); // [RQ19]

  property p_byte_step;
    ce && cyc_start && xr_req && !xr_dsp && xr_byte && !xr_mod_en
      && xr_pm == dag_pkg::DAG_PM_DEC |=> xr_ptr_upd == $past(xr_ptr) - 16'h0001;
  endproperty
  a_byte_step: assert property (p_byte_step) else $error("byte step not 1"); // [RQ21]

  property p_byte_lane;
    ce && x_rd_en && s_q.xr_byte && s_q.xr_ea[0]
      |=> x_rd_data == {8'h00, $past(x_mem_rdata[15:8])};
  endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("odd byte not on low lane"); // [RQ18]

  property p_mis_wr;
    ce && wr_phase && s_q.xw_pend && !s_q.xw_byte && s_q.xw_ea[0]
      |=> !x_wr_en && addr_err_trap && s_q.fault_wr && s_q.fault_ea == $past(s_q.xw_ea);
  endproperty
  a_mis_wr: assert property (p_mis_wr) else $error("misaligned write not suppressed"); // [RQ20]

  property p_word_addr;
    x_rd_en && !s_q.xr_byte |-> !x_rd_addr[0];
  endproperty
  a_word_addr: assert property (p_word_addr) else $error("word address bit 0 set"); // [RQ16]

  property p_cov_dual;
    x_rd_en && y_rd_en;
  endproperty
  c_cov_dual: cover property (p_cov_dual);

  property p_cov_brev;
    ce && cyc_start && xw_req && xw_brev && brev_act;
  endproperty
  c_cov_brev: cover property (p_cov_brev);

  property p_cov_trap;
    addr_err_trap && s_q.fault_wr;
  endproperty
  c_cov_trap: cover property (p_cov_trap);

endmodule

// file: dag_mem_model.sv
`timescale 1ns/1ps
module dag_mem_model (
  // Clock
  input wire logic clk,
  // Read buses
  input wire logic [15:0] x_rd_addr,
  input wire logic x_rd_en,
  output logic [15:0] x_mem_rdata,
  input wire logic [15:0] y_rd_addr,
  input wire logic y_rd_en,
  output logic [15:0] y_mem_rdata,
  // Write bus
  input wire logic [15:0] x_wr_addr,
  input wire logic x_wr_en,
  input wire logic [1:0] x_wr_be,
  input wire logic [15:0] x_wr_data
);
  logic [15:0] mem [0:127];
  logic [15:0] pat;
  initial
  begin
    pat = 16'h0000;
    for (int i = 0; i < 128; i++) mem[i] = 16'h0000;
  end
  // Only low address bits decode, so high addresses alias real words
  // Idle buses show a changing pattern rather than a held value
  assign x_mem_rdata = x_rd_en ? mem[x_rd_addr[7:1]] : pat;
  assign y_mem_rdata = y_rd_en ? mem[y_rd_addr[7:1]] : ~pat;
  always @(posedge clk)
  begin
    pat <= pat + 16'h1357;
    if (x_wr_en && x_wr_be[0]) mem[x_wr_addr[7:1]][7:0] <= x_wr_data[7:0];
    if (x_wr_en && x_wr_be[1]) mem[x_wr_addr[7:1]][15:8] <= x_wr_data[15:8];
  end
endmodule

// file: data_space_address_generators_test.sv
`timescale 1ns/1ps
module data_space_address_generators_test;
  logic clk, rst_n, ce, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic cyc_start, wr_phase, xr_req, xr_dsp, xr_byte, xr_mod_en, y_req, y_mod_en;
  logic xw_req, xw_byte, xw_mod_en, xw_brev, x_rd_en, y_rd_en, x_wr_en, rd_valid;
  logic addr_err_trap, rerr;
  logic [3:0] xr_wreg, y_wreg;
  logic [15:0] xr_ptr, y_ptr, xw_ptr, xw_data, x_mod_start, x_mod_end, y_mod_start;
  logic [15:0] y_mod_end, x_rd_addr, x_mem_rdata, y_rd_addr, y_mem_rdata, x_wr_addr;
  logic [15:0] x_wr_data, x_rd_data, y_rd_data, xr_ptr_upd, y_ptr_upd, xw_ptr_upd;
  logic [1:0] x_wr_be;
  dag_pkg::dag_pm_e xr_pm, y_pm, xw_pm;
  int err_total, comparisons, trap_cnt, tc;
  logic [15:0] tp [4] = '{16'h0010, 16'h0011, 16'h0010, 16'h8010};
  logic [15:0] td [4] = '{16'hA55A, 16'h00A5, 16'h005A, 16'h0000};
  logic [15:0] tu [4] = '{16'h0012, 16'h0012, 16'h000F, 16'h8010};
  logic [3:0] tb = 4'h6;
  dag_pkg::dag_pm_e tm [4] = '{dag_pkg::DAG_PM_INC, dag_pkg::DAG_PM_INC,
    dag_pkg::DAG_PM_DEC, dag_pkg::DAG_PM_NONE};
  dag_agu DUT (.clk, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cyc_start, .wr_phase, .xr_req, .xr_dsp, .xr_wreg, .xr_ptr,
    .xr_byte, .xr_pm, .xr_mod_en, .y_req, .y_wreg, .y_ptr, .y_pm, .y_mod_en, .xw_req,
    .xw_ptr, .xw_byte, .xw_pm, .xw_mod_en, .xw_brev, .xw_data, .x_mod_start,
    .x_mod_end, .y_mod_start, .y_mod_end, .x_rd_addr, .x_rd_en, .x_mem_rdata,
    .y_rd_addr, .y_rd_en, .y_mem_rdata, .x_wr_addr, .x_wr_en, .x_wr_be, .x_wr_data,
    .x_rd_data, .y_rd_data, .rd_valid, .xr_ptr_upd, .y_ptr_upd, .xw_ptr_upd,
    .addr_err_trap);
  dag_mem_model mem_i (.clk, .x_rd_addr, .x_rd_en, .x_mem_rdata, .y_rd_addr, .y_rd_en,
    .y_mem_rdata, .x_wr_addr, .x_wr_en, .x_wr_be, .x_wr_data);
  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) if (addr_err_trap === 1'h1) trap_cnt++;
  task summarize;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask
  task hang(input string n);
    $display("ERROR %s expected answer seen none", n);
    err_total++;
    summarize;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) hang("pready");
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task rd(input logic dsp, input logic [3:0] w, input logic [15:0] p, input logic b,
    input dag_pkg::dag_pm_e pm, input logic md, input logic yq);
    int n;
    @(posedge clk);
    cyc_start <= 1'h1;
    xr_req <= 1'h1;
    xr_dsp <= dsp;
    xr_wreg <= w;
    xr_ptr <= p;
    xr_byte <= b;
    xr_pm <= pm;
    xr_mod_en <= md;
    y_req <= yq;
    @(posedge clk);
    cyc_start <= 1'h0;
    xr_req <= 1'h0;
    y_req <= 1'h0;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (rd_valid !== 1'h1 && n < 6);
    if (rd_valid !== 1'h1) hang("rd_valid");
  endtask
  task wr(input logic [15:0] p, input logic b, input dag_pkg::dag_pm_e pm,
    input logic md, input logic bv, input logic [15:0] d);
    @(posedge clk);
    cyc_start <= 1'h1;
    xw_req <= 1'h1;
    xw_ptr <= p;
    xw_byte <= b;
    xw_pm <= pm;
    xw_mod_en <= md;
    xw_brev <= bv;
    xw_data <= d;
    @(posedge clk);
    cyc_start <= 1'h0;
    xw_req <= 1'h0;
    wr_phase <= 1'h1;
    @(posedge clk);
    wr_phase <= 1'h0;
    repeat (2) @(posedge clk);
  endtask
  initial
  begin
    {rst_n, psel, penable, pwrite, cyc_start, wr_phase, xr_req, xr_dsp} = 8'h00;
    {xr_byte, xr_mod_en, y_req, y_mod_en, xw_req, xw_byte, xw_mod_en, xw_brev} = 8'h00;
    {paddr, pwdata, xr_wreg, y_wreg} = 52'h0;
    {xr_ptr, y_ptr, xw_ptr, xw_data} = 64'h0;
    {x_mod_start, x_mod_end, y_mod_start, y_mod_end} = {16'h0040, 16'h0047, 32'h0};
    xr_pm = dag_pkg::DAG_PM_NONE;
    y_pm = dag_pkg::DAG_PM_NONE;
    xw_pm = dag_pkg::DAG_PM_NONE;
    ce = 1'h1;
    err_total = 0;
    comparisons = 0;
    trap_cnt = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'h1;
    apb(1'h0, 12'h000, 32'h0);
    chk("brev reset", 16'h0000, rdat[15:0]);
    apb(1'h1, 12'h000, 32'h8008);
    apb(1'h0, 12'h000, 32'h0);
    chk("brev rw", 16'h8008, rdat[15:0]);
    apb(1'h0, 12'h004, 32'h0);
    chk("brev active", 16'h0001, rdat[15:0] & 16'h0001);
    wr(16'h0010, 1'h0, dag_pkg::DAG_PM_INC, 1'h0, 1'h1, 16'h1111);
    chk("brev ptr", 16'h0008, xw_ptr_upd);
    apb(1'h1, 12'h000, 32'h8003);
    apb(1'h0, 12'h004, 32'h0);
    chk("bad modifier", 16'h0000, rdat[15:0] & 16'h0001);
    apb(1'h1, 12'h000, 32'h0008);
    wr(16'h0010, 1'h0, dag_pkg::DAG_PM_INC, 1'h0, 1'h1, 16'hA55A);
    chk("brev off ptr", 16'h0012, xw_ptr_upd);
    apb(1'h0, 12'h008, 32'h0);
    chk("unmapped", 16'h0001, {15'h0, rerr});
    wr(16'h0013, 1'h1, dag_pkg::DAG_PM_INC, 1'h0, 1'h0, 16'h00C3);
    chk("byte wr ptr", 16'h0014, xw_ptr_upd);
    for (int i = 0; i < 4; i++)
    begin
      rd(1'h0, 4'hA, tp[i], tb[i], tm[i], 1'h0, 1'h0);
      chk("x data", td[i], x_rd_data);
      chk("x ptr", tu[i], xr_ptr_upd);
    end
    tc = trap_cnt;
    rd(1'h0, 4'h1, 16'h0011, 1'h0, dag_pkg::DAG_PM_NONE, 1'h0, 1'h0);
    chk("odd rd data", 16'hA55A, x_rd_data);
    wr(16'h0015, 1'h0, dag_pkg::DAG_PM_NONE, 1'h0, 1'h0, 16'hBEEF);
    wr(16'h8010, 1'h0, dag_pkg::DAG_PM_NONE, 1'h0, 1'h0, 16'hFFFF);
    chk("traps", 16'h0002, 16'(trap_cnt - tc));
    apb(1'h0, 12'h004, 32'h0);
    chk("fault ea", 16'h0015, rdat[31:16]);
    chk("fault wr", 16'h0004, rdat[15:0] & 16'h0004);
    rd(1'h0, 4'h1, 16'h0014, 1'h0, dag_pkg::DAG_PM_NONE, 1'h0, 1'h0);
    chk("odd wr kept", 16'h0000, x_rd_data);
    y_wreg <= 4'hA;
    y_ptr <= 16'h0012;
    y_pm <= dag_pkg::DAG_PM_DEC;
    rd(1'h1, 4'h8, 16'h0010, 1'h0, dag_pkg::DAG_PM_NONE, 1'h0, 1'h1);
    chk("dsp x", 16'hA55A, x_rd_data);
    chk("dsp y", 16'hC300, y_rd_data);
    chk("y ptr", 16'h0010, y_ptr_upd);
    rd(1'h1, 4'hA, 16'h0010, 1'h0, dag_pkg::DAG_PM_NONE, 1'h0, 1'h1);
    apb(1'h0, 12'h004, 32'h0);
    chk("sel err", 16'h0002, rdat[15:0] & 16'h0002);
    apb(1'h1, 12'h004, 32'h0002);
    apb(1'h0, 12'h004, 32'h0);
    chk("sel err clear", 16'h0000, rdat[15:0] & 16'h0002);
    y_ptr <= 16'h0046;
    y_pm <= dag_pkg::DAG_PM_INC;
    y_mod_en <= 1'h1;
    y_mod_start <= 16'h0040;
    y_mod_end <= 16'h0047;
    rd(1'h1, 4'h9, 16'h0010, 1'h0, dag_pkg::DAG_PM_NONE, 1'h0, 1'h1);
    chk("y mod", 16'h0040, y_ptr_upd);
    rd(1'h0, 4'h2, 16'h0046, 1'h0, dag_pkg::DAG_PM_INC, 1'h1, 1'h0);
    chk("mod rd", 16'h0040, xr_ptr_upd);
    wr(16'h0040, 1'h0, dag_pkg::DAG_PM_DEC, 1'h1, 1'h0, 16'h0001);
    chk("mod wr", 16'h0046, xw_ptr_upd);
    summarize;
  end
endmodule
